//--- cbc_bus_ctrl.sv
// Bus-cycle controller top: runs memory, I/O, fetch, interrupt
// acknowledge, unmaskable restart and halt cycles, and hands the bus over.
// Assumes a core issues cycle commands; pins are synchronous to mclk and
// the testbench resolves the three-state wires from the enables.
`timescale 1ns/1ps
`default_nettype none
module cbc_bus_ctrl (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire cbc_pkg::cbc_cmd_t cmd,
  output logic cmd_ready,
  output cbc_pkg::cbc_resp_t resp,
  input wire logic int_enable,
  input wire logic maskable_interrupt_n,
  input wire logic unmaskable_interrupt_n,
  input wire logic wait_n,
  input wire logic bus_request_n,
  input wire logic [7:0] data_in,
  output cbc_pkg::cbc_bus_t bus,
  output logic bus_grant_n,
  output logic stopped_indicator_n
);
  cbc_pkg::cbc_full_t s_reg;
  cbc_pkg::cbc_full_t s_next;
  logic sample;
  logic end_cyc;
  logic take_nmi;
  logic take_int;
  logic [1:0] aw;

  function automatic logic [1:0] auto_waits(input cbc_pkg::cbc_cyc_t c);
    case (c)
      cbc_pkg::CBC_IO_RD, cbc_pkg::CBC_IO_WR: begin
        auto_waits = cbc_pkg::CBC_IO_AUTO_WAITS;
      end
      cbc_pkg::CBC_INTA: begin
        auto_waits = cbc_pkg::CBC_INTA_AUTO_WAITS;
      end
      default: begin
        auto_waits = cbc_pkg::CBC_ZERO2;
      end
    endcase
  endfunction : auto_waits

  function automatic logic fetch_like(input cbc_pkg::cbc_cyc_t c);
    fetch_like = (c == cbc_pkg::CBC_FETCH) || (c == cbc_pkg::CBC_INTA) ||
                 (c == cbc_pkg::CBC_NMI) || (c == cbc_pkg::CBC_NOP);
  endfunction : fetch_like

  // Strobe pattern for a state; registered so the pins come from flops
  function automatic cbc_pkg::cbc_bus_t drive(
    input cbc_pkg::cbc_state_t st,
    input cbc_pkg::cbc_cyc_t c,
    input logic [15:0] a,
    input logic [7:0] wd,
    input logic [6:0] rf
  );
    logic is_mem;
    logic is_io;
    logic is_rd;
    logic is_wr;
    cbc_pkg::cbc_bus_t d;
    is_mem = (c == cbc_pkg::CBC_MEM_RD) || (c == cbc_pkg::CBC_MEM_WR) ||
             (c == cbc_pkg::CBC_FETCH) || (c == cbc_pkg::CBC_NMI) ||
             (c == cbc_pkg::CBC_NOP);
    is_io = (c == cbc_pkg::CBC_IO_RD) || (c == cbc_pkg::CBC_IO_WR);
    is_rd = is_mem && (c != cbc_pkg::CBC_MEM_WR) || (c == cbc_pkg::CBC_IO_RD);
    is_wr = (c == cbc_pkg::CBC_MEM_WR) || (c == cbc_pkg::CBC_IO_WR);
    d = cbc_pkg::CBC_BUS_FLOAT;
    d.ctl_oe = 1'b1;
    d.addr_oe = 1'b1;
    d.addr = a;
    d.data = wd;
    d.data_oe = is_wr && (st != cbc_pkg::S_IDLE);
    case (st)
      cbc_pkg::S_T1: begin
        d.memory_request_n = ~is_mem;
        d.read_strobe_n = ~(is_mem && is_rd);
        d.opcode_fetch_cycle_n = ~fetch_like(c);
      end
      cbc_pkg::S_T2, cbc_pkg::S_TW, cbc_pkg::S_T3: begin
        d.memory_request_n = ~is_mem;
        d.io_request_n = ~(is_io || ((c == cbc_pkg::CBC_INTA) &&
                         (st != cbc_pkg::S_T2)));
        d.read_strobe_n = ~is_rd;
        d.store_strobe_n = ~is_wr;
        d.opcode_fetch_cycle_n = ~fetch_like(c);
      end
      cbc_pkg::S_T4: begin
        d.memory_request_n = 1'b0;
        d.refresh_n = 1'b0;
        d.addr = {cbc_pkg::CBC_RFSH_PAD, rf};
      end
      default: begin
      end
    endcase
    drive = d;
  endfunction : drive

  cbc_irq_sampler u_irq (
    .mclk(mclk),
    .rst(rst),
    .unmaskable_interrupt_n(unmaskable_interrupt_n),
    .maskable_interrupt_n(maskable_interrupt_n),
    .int_enable(int_enable),
    .sample(sample),
    .take_nmi(take_nmi),
    .take_int(take_int)
  );

  // A command is taken only when no bus hand-over or interrupt is due
  assign cmd_ready = (s_reg.st == cbc_pkg::S_IDLE) && bus_request_n &&
                     !s_reg.pend_nmi && !s_reg.pend_int && !s_reg.halted &&
                     !rst;
  assign aw = auto_waits(s_reg.cyc);
  // Cycle end and sample point kept out of the state process, so the
  // sampler's answer never feeds the process that asks it
  assign end_cyc = ((s_reg.st == cbc_pkg::S_T3) && !fetch_like(s_reg.cyc)) ||
                   (s_reg.st == cbc_pkg::S_T4);
  assign sample = end_cyc && s_reg.last;
  assign resp = s_reg.resp;
  assign bus = s_reg.bus;
  assign bus_grant_n = s_reg.grant_n;
  assign stopped_indicator_n = ~s_reg.halted;

  always_comb begin
    s_next = s_reg;
    s_next.resp.valid = 1'b0;
    case (s_reg.st)
      cbc_pkg::S_RST_GAP: begin
        if (s_reg.gap == cbc_pkg::CBC_RESET_GAP - cbc_pkg::CBC_ONE2) begin
          s_next.st = cbc_pkg::S_IDLE;
        end else begin
          s_next.gap = s_reg.gap + cbc_pkg::CBC_ONE2;
        end
      end
      cbc_pkg::S_IDLE: begin
        s_next.waits = cbc_pkg::CBC_ZERO2;
        s_next.last = 1'b0;
        s_next.halt_after = 1'b0;
        s_next.addr_q = s_reg.pc;
        if (!bus_request_n) begin
          s_next.st = cbc_pkg::S_HELD;
        end else if (s_reg.pend_nmi) begin
          s_next.st = cbc_pkg::S_T1;
          s_next.cyc = cbc_pkg::CBC_NMI;
          s_next.pend_nmi = 1'b0;
        end else if (s_reg.pend_int) begin
          s_next.st = cbc_pkg::S_T1;
          s_next.cyc = cbc_pkg::CBC_INTA;
          s_next.pend_int = 1'b0;
        end else if (s_reg.halted) begin
          s_next.st = cbc_pkg::S_T1;
          s_next.cyc = cbc_pkg::CBC_NOP;
          s_next.last = 1'b1;
          s_next.halt_after = 1'b1;
        end else if (cmd_valid) begin
          s_next.st = cbc_pkg::S_T1;
          s_next.cyc = cmd.cyc;
          s_next.last = cmd.last;
          s_next.halt_after = cmd.halt;
          s_next.wdata_q = cmd.wdata;
          if (cmd.cyc != cbc_pkg::CBC_FETCH) begin
            s_next.addr_q = cmd.addr;
          end
        end
      end
      cbc_pkg::S_T1: begin
        s_next.st = cbc_pkg::S_T2;
      end
      cbc_pkg::S_T2: begin
        if (aw != cbc_pkg::CBC_ZERO2) begin
          s_next.st = cbc_pkg::S_TW;
          s_next.waits = aw - cbc_pkg::CBC_ONE2;
        end else if (!wait_n) begin
          s_next.st = cbc_pkg::S_TW;
        end else begin
          s_next.st = cbc_pkg::S_T3;
        end
      end
      cbc_pkg::S_TW: begin
        if (s_reg.waits != cbc_pkg::CBC_ZERO2) begin
          s_next.waits = s_reg.waits - cbc_pkg::CBC_ONE2;
        end else if (wait_n) begin
          s_next.st = cbc_pkg::S_T3;
        end
      end
      cbc_pkg::S_T3: begin
        s_next.resp.data = data_in;
        s_next.resp.cyc = s_reg.cyc;
        if (fetch_like(s_reg.cyc)) begin
          s_next.st = cbc_pkg::S_T4;
        end
      end
      cbc_pkg::S_T4: begin
        s_next.rfsh = s_reg.rfsh + cbc_pkg::CBC_RFSH_STEP;
      end
      cbc_pkg::S_HELD: begin
        // Held until release; the next cycle starts from idle
        if (bus_request_n) begin
          s_next.st = cbc_pkg::S_IDLE;
        end
      end
      default: begin
        s_next.st = cbc_pkg::S_IDLE;
      end
    endcase

    if (end_cyc) begin
      s_next.st = bus_request_n ? cbc_pkg::S_IDLE : cbc_pkg::S_HELD;
      s_next.resp.valid = (s_reg.cyc != cbc_pkg::CBC_NMI) &&
                          (s_reg.cyc != cbc_pkg::CBC_NOP) &&
                          (s_reg.cyc != cbc_pkg::CBC_MEM_WR) &&
                          (s_reg.cyc != cbc_pkg::CBC_IO_WR);
      if (s_reg.cyc == cbc_pkg::CBC_FETCH) begin
        s_next.pc = s_reg.pc + cbc_pkg::CBC_PC_STEP;
      end
      if (s_reg.cyc == cbc_pkg::CBC_NMI) begin
        s_next.pc = cbc_pkg::CBC_NMI_PC;
      end
      if (take_nmi) begin
        s_next.pend_nmi = 1'b1;
        s_next.halted = 1'b0;
      end else if (take_int) begin
        s_next.pend_int = 1'b1;
        s_next.halted = 1'b0;
      end else if (s_reg.last && s_reg.halt_after) begin
        s_next.halted = 1'b1;
      end
    end

    // Float in the same edge that grants, so the requester never contends
    if (s_next.st == cbc_pkg::S_HELD || s_next.st == cbc_pkg::S_RST_GAP) begin
      s_next.bus = cbc_pkg::CBC_BUS_FLOAT;
    end else begin
      s_next.bus = drive(s_next.st, s_next.cyc, s_next.addr_q,
                         s_next.wdata_q, s_reg.rfsh);
    end
    s_next.grant_n = (s_next.st != cbc_pkg::S_HELD);

    if (rst) begin
      // Held each cycle of reset: floated bus, pc at zero
      s_next = cbc_pkg::CBC_FULL_RESET;
    end
  end

  always_ff @(posedge mclk) begin
    s_reg <= s_next;
  end
endmodule : cbc_bus_ctrl
`default_nettype wire

//--- cbc_pkg.sv
// Package for the bus-cycle controller: cycle kinds, states, carriers,
// timing counts and reset values.
// Assumes one 50 MHz clock and a synchronous active-high reset.
`default_nettype none
package cbc_pkg;

  typedef enum logic [2:0] {
    CBC_MEM_RD, CBC_MEM_WR, CBC_IO_RD, CBC_IO_WR,
    CBC_FETCH, CBC_INTA, CBC_NMI, CBC_NOP
  } cbc_cyc_t;

  typedef enum logic [2:0] {
    S_RST_GAP, S_IDLE, S_T1, S_T2, S_TW, S_T3, S_T4, S_HELD
  } cbc_state_t;

  localparam logic [1:0] CBC_ONE2 = 2'h1;
  localparam logic [1:0] CBC_ZERO2 = 2'h0;
  localparam logic [1:0] CBC_IO_AUTO_WAITS = 2'h1;
  localparam logic [1:0] CBC_INTA_AUTO_WAITS = 2'h2;
  localparam logic [1:0] CBC_RESET_GAP = 2'h3;
  localparam logic [15:0] CBC_RESET_PC = 16'h0000;
  localparam logic [15:0] CBC_NMI_PC = 16'h0066;
  localparam logic [15:0] CBC_PC_STEP = 16'h0001;
  localparam logic [6:0] CBC_RFSH_STEP = 7'h01;
  localparam logic [8:0] CBC_RFSH_PAD = 9'h000;

  typedef struct packed {
    cbc_cyc_t cyc;
    logic halt;
    logic last;
    logic [15:0] addr;
    logic [7:0] wdata;
  } cbc_cmd_t;

  typedef struct packed {
    logic [15:0] addr;
    logic addr_oe;
    logic [7:0] data;
    logic data_oe;
    logic ctl_oe;
    logic memory_request_n;
    logic io_request_n;
    logic read_strobe_n;
    logic store_strobe_n;
    logic opcode_fetch_cycle_n;
    logic refresh_n;
  } cbc_bus_t;

  typedef struct packed {
    logic valid;
    cbc_cyc_t cyc;
    logic [7:0] data;
  } cbc_resp_t;

  typedef struct packed {
    logic nmi_level;
    logic nmi_pend;
  } cbc_irq_t;

  typedef struct packed {
    cbc_state_t st;
    cbc_cyc_t cyc;
    logic [1:0] waits;
    logic [1:0] gap;
    logic [15:0] pc;
    logic [15:0] addr_q;
    logic [7:0] wdata_q;
    logic [6:0] rfsh;
    logic halted;
    logic last;
    logic halt_after;
    logic pend_nmi;
    logic pend_int;
    logic grant_n;
    cbc_bus_t bus;
    cbc_resp_t resp;
  } cbc_full_t;

  localparam cbc_bus_t CBC_BUS_FLOAT = '{
    addr: 16'h0000, addr_oe: 1'b0, data: 8'h00, data_oe: 1'b0,
    ctl_oe: 1'b0, memory_request_n: 1'b1, io_request_n: 1'b1,
    read_strobe_n: 1'b1, store_strobe_n: 1'b1,
    opcode_fetch_cycle_n: 1'b1, refresh_n: 1'b1};

  localparam cbc_irq_t CBC_IRQ_RESET = '{nmi_level: 1'b1, nmi_pend: 1'b0};

  localparam cbc_full_t CBC_FULL_RESET = '{
    st: S_RST_GAP, cyc: CBC_NOP, waits: 2'h0, gap: 2'h0,
    pc: CBC_RESET_PC, addr_q: 16'h0000, wdata_q: 8'h00, rfsh: 7'h00,
    halted: 1'b0, last: 1'b0, halt_after: 1'b0, pend_nmi: 1'b0,
    pend_int: 1'b0, grant_n: 1'b1, bus: CBC_BUS_FLOAT,
    resp: '{valid: 1'b0, cyc: CBC_NOP, data: 8'h00}};

endpackage : cbc_pkg
`default_nettype wire

//--- cbc_irq_sampler.sv
// Interrupt sampler: latches unmaskable falling edges and decides, at an
// instruction end, which interrupt is taken.
// Assumes interrupt pins are synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
module cbc_irq_sampler (
  input wire logic mclk,
  input wire logic rst,
  input wire logic unmaskable_interrupt_n,
  input wire logic maskable_interrupt_n,
  input wire logic int_enable,
  input wire logic sample,
  output logic take_nmi,
  output logic take_int
);
  cbc_pkg::cbc_irq_t s_reg;
  cbc_pkg::cbc_irq_t s_next;
  logic edge_seen;

  // Only an edge counts; a held low level is not taken twice
  assign edge_seen = s_reg.nmi_level & ~unmaskable_interrupt_n;
  // Unmaskable wins and ignores the enable
  assign take_nmi = sample & s_reg.nmi_pend;
  assign take_int = sample & ~s_reg.nmi_pend & ~maskable_interrupt_n &
                    int_enable;

  always_comb begin
    s_next = s_reg;
    s_next.nmi_level = unmaskable_interrupt_n;
    // A new edge in the taking cycle survives
    s_next.nmi_pend = (s_reg.nmi_pend & ~take_nmi) | edge_seen;
    if (rst) begin
      s_next = cbc_pkg::CBC_IRQ_RESET;
    end
  end

  always_ff @(posedge mclk) begin
    s_reg <= s_next;
  end
endmodule : cbc_irq_sampler
`default_nettype wire

//--- cbc_bus_ctrl_props.sv
// Port checker for the bus-cycle controller.
// Assumes one mclk domain and the controller's registered outputs.
`timescale 1ns/1ps
`default_nettype none
module cbc_bus_ctrl_props (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire cbc_pkg::cbc_cmd_t cmd,
  input wire logic cmd_ready,
  input wire cbc_pkg::cbc_resp_t resp,
  input wire logic int_enable,
  input wire logic maskable_interrupt_n,
  input wire logic unmaskable_interrupt_n,
  input wire logic wait_n,
  input wire logic bus_request_n,
  input wire logic [7:0] data_in,
  input wire cbc_pkg::cbc_bus_t bus,
  input wire logic bus_grant_n,
  input wire logic stopped_indicator_n
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // A fall latched while halted may wake the core at any later NOP end
  logic nmi_seen;
  always_ff @(posedge mclk) begin
    if (rst) begin
      nmi_seen <= 1'b0;
    end else begin
      nmi_seen <= $fell(unmaskable_interrupt_n) ||
                  (nmi_seen && !stopped_indicator_n);
    end
  end
  sequence io_rd_take;
    cmd_valid && cmd_ready && cmd.cyc == cbc_pkg::CBC_IO_RD;
  endsequence
  sequence ack_open;
    $fell(bus.io_request_n) && !bus.opcode_fetch_cycle_n;
  endsequence
  AST_RST_FLOAT: assert property ($fell(rst) |-> bus_grant_n &&
    !(bus.addr_oe || bus.data_oe || bus.ctl_oe) && bus.read_strobe_n)
    else $error("bus driven at reset release");
  AST_RST_GAP: assert property ($fell(rst) |-> !cmd_ready [*3])
    else $error("ready too soon after reset");
  AST_IO_WAIT: assert property (io_rd_take ##1 wait_n [*4]
    |-> !resp.valid ##1 resp.valid)
    else $error("io read length wrong");
  AST_ACK_NO_MEM: assert property (!bus.opcode_fetch_cycle_n &&
    !bus.io_request_n |-> bus.memory_request_n)
    else $error("memory request in acknowledge");
  AST_ACK_WAITS: assert property (ack_open |-> !bus.io_request_n [*3])
    else $error("acknowledge too short");
  AST_NMI_QUIET: assert property (resp.valid |->
    resp.cyc != cbc_pkg::CBC_NMI)
    else $error("restart fetch answered");
  AST_GRANT_FLOAT: assert property (!bus_grant_n |->
    !(bus.addr_oe || bus.data_oe || bus.ctl_oe))
    else $error("bus driven while granted");
  AST_GRANT_CAUSE: assert property ($fell(bus_grant_n) |->
    !$past(bus_request_n))
    else $error("grant without request");
  AST_GRANT_HOLD: assert property (!bus_grant_n && !bus_request_n
    |=> !bus_grant_n)
    else $error("grant dropped early");
  AST_GRANT_BACK: assert property (!bus_grant_n && bus_request_n
    |=> bus_grant_n)
    else $error("grant kept after release");
  AST_HALT_HOLD: assert property (!stopped_indicator_n &&
    (maskable_interrupt_n || !int_enable) && !nmi_seen
    |=> !stopped_indicator_n)
    else $error("halt indication lost");
  AST_RFSH_SLOT: assert property (!bus.refresh_n |->
    !bus.memory_request_n && bus.read_strobe_n && bus.opcode_fetch_cycle_n)
    else $error("refresh slot strobes wrong");
endmodule : cbc_bus_ctrl_props
bind cbc_bus_ctrl cbc_bus_ctrl_props u_props (.mclk(mclk), .rst(rst),
  .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .resp(resp),
  .int_enable(int_enable), .maskable_interrupt_n(maskable_interrupt_n),
  .unmaskable_interrupt_n(unmaskable_interrupt_n), .wait_n(wait_n),
  .bus_request_n(bus_request_n), .data_in(data_in), .bus(bus),
  .bus_grant_n(bus_grant_n), .stopped_indicator_n(stopped_indicator_n));
`default_nettype wire

//--- cbc_mem_model.sv
// Memory, port and interrupter model facing the controller's bus.
// Assumes registered strobes; a released data line shows a moving pattern.
`timescale 1ns/1ps
`default_nettype none
module cbc_mem_model #(parameter logic [7:0] VECTOR = 8'h3c) (
  input wire logic mclk,
  input wire logic rst,
  input wire cbc_pkg::cbc_bus_t bus,
  input wire logic slow,
  output logic [7:0] data_in,
  output logic wait_n
);
  logic rd;
  logic ack;
  logic [1:0] age;
  logic [7:0] last;
  assign rd = bus.ctl_oe && !bus.read_strobe_n;
  assign ack = bus.ctl_oe && !bus.io_request_n && !bus.opcode_fetch_cycle_n;
  // Undriven lines invert each cycle so a stale byte never passes
  always_comb begin
    if (ack)
      data_in = VECTOR;
    else if (rd && !bus.memory_request_n)
      data_in = bus.addr[7:0] ^ bus.addr[15:8] ^ 8'h5a;
    else if (rd)
      data_in = ~bus.addr[7:0];
    else
      data_in = ~last;
  end
  // Slow mode stretches a read by one cycle in its second strobe cycle
  assign wait_n = !(slow && rd && age == 2'h1);
  always_ff @(posedge mclk) begin
    age <= rd ? age + 2'h1 : 2'h0;
    last <= rst ? 8'h00 : data_in;
  end
endmodule : cbc_mem_model
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the bus-cycle controller with a far-side model.
// Assumes the port checker is bound from its own file.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [7:0] VEC = 8'h3c;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  cbc_pkg::cbc_cmd_t cmd = '0;
  logic int_enable = 1'b0;
  logic mint_n = 1'b1;
  logic nmi_n = 1'b1;
  logic breq_n = 1'b1;
  logic slow = 1'b0;
  logic cmd_ready, wait_n, bus_grant_n, stopped_indicator_n;
  logic [7:0] data_in;
  cbc_pkg::cbc_resp_t resp;
  cbc_pkg::cbc_bus_t bus;
  logic [10:0] expq[$];
  logic [10:0] e;
  logic [15:0] pc_exp = 16'h0000;
  logic [31:0] seed = 32'hca07;
  logic [31:0] r;
  int n_errors = 0;
  int check_count = 0;
  int i;
  int k;
  always #10 mclk = ~mclk;
  cbc_bus_ctrl dut (.mclk(mclk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd(cmd), .cmd_ready(cmd_ready), .resp(resp), .int_enable(int_enable),
    .maskable_interrupt_n(mint_n), .unmaskable_interrupt_n(nmi_n),
    .wait_n(wait_n), .bus_request_n(breq_n), .data_in(data_in), .bus(bus),
    .bus_grant_n(bus_grant_n), .stopped_indicator_n(stopped_indicator_n));
  cbc_mem_model #(.VECTOR(VEC)) u_mem (.mclk(mclk), .rst(rst), .bus(bus),
    .slow(slow), .data_in(data_in), .wait_n(wait_n));
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task summarize;
    if (n_errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize
  function automatic logic [7:0] mdata(logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction : mdata
  // Offer one command, note its answer, check the address in T1
  task automatic run(cbc_pkg::cbc_cyc_t c, logic [15:0] a, logic l,
    logic h);
    logic [15:0] ea;
    ea = (c == cbc_pkg::CBC_FETCH) ? pc_exp : a;
    cmd_valid <= 1'b1;
    cmd <= '{cyc: c, halt: h, last: l, addr: a, wdata: ~a[7:0]};
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (cmd_ready !== 1'b1 && i < 300);
    if (cmd_ready !== 1'b1)
      n_errors++;
    cmd_valid <= 1'b0;
    if (c == cbc_pkg::CBC_FETCH || c == cbc_pkg::CBC_MEM_RD)
      expq.push_back({c, mdata(ea)});
    else if (c == cbc_pkg::CBC_IO_RD)
      expq.push_back({c, ~a[7:0]});
    if (c == cbc_pkg::CBC_FETCH)
      pc_exp = pc_exp + 16'h0001;
    @(posedge mclk);
    chk(bus.addr, ea);
  endtask : run
  task automatic drain;
    i = 0;
    while (expq.size() != 0 && i < 300) begin
      @(posedge mclk);
      i++;
    end
    if (expq.size() != 0)
      n_errors++;
    repeat (2) @(posedge mclk);
  endtask : drain
  always @(posedge mclk) begin
    if (resp.valid === 1'b1) begin
      e = (expq.size() != 0) ? expq.pop_front() : 11'h7ff;
      chk(16'({resp.cyc, resp.data}), 16'(e));
    end
  end
  // Every write carries the inverted low address byte as its data
  always @(posedge mclk) begin
    if (bus.ctl_oe === 1'b1 && bus.store_strobe_n === 1'b0)
      chk(16'({bus.data_oe, bus.data}), 16'({1'b1, ~bus.addr[7:0]}));
  end
  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    run(cbc_pkg::CBC_FETCH, 16'h0000, 1'b0, 1'b0);
    for (k = 0; k < 12; k++) begin
      r = $random(seed);
      if (k < 5)
        r[18:16] = 3'(k);
      run(cbc_pkg::cbc_cyc_t'(r[18:16] % 3'h5), r[15:0], 1'b0, 1'b0);
    end
    slow <= 1'b1;
    run(cbc_pkg::CBC_MEM_RD, 16'h1234, 1'b0, 1'b0);
    drain();
    slow <= 1'b0;
    mint_n <= 1'b0;
    run(cbc_pkg::CBC_MEM_RD, 16'h00ff, 1'b1, 1'b0);
    drain();
    int_enable <= 1'b1;
    run(cbc_pkg::CBC_MEM_RD, 16'hff00, 1'b1, 1'b0);
    expq.push_back({cbc_pkg::CBC_INTA, VEC});
    drain();
    // Falls well before the end state so the next sample sees it
    nmi_n <= 1'b0;
    run(cbc_pkg::CBC_MEM_RD, 16'h0f0f, 1'b1, 1'b0);
    nmi_n <= 1'b1;
    drain();
    mint_n <= 1'b1;
    int_enable <= 1'b0;
    pc_exp = 16'h0066;
    run(cbc_pkg::CBC_FETCH, 16'h0000, 1'b0, 1'b0);
    run(cbc_pkg::CBC_IO_RD, 16'h00a5, 1'b0, 1'b0);
    breq_n <= 1'b0;
    repeat (12) @(posedge mclk);
    chk(16'({bus_grant_n, bus.addr_oe, bus.ctl_oe}), 16'h0);
    breq_n <= 1'b1;
    drain();
    chk(16'(bus_grant_n), 16'h1);
    run(cbc_pkg::CBC_FETCH, 16'h0000, 1'b0, 1'b0);
    run(cbc_pkg::CBC_FETCH, 16'h0000, 1'b1, 1'b1);
    repeat (8) @(posedge mclk);
    k = 0;
    repeat (30) begin
      @(posedge mclk);
      if (bus.opcode_fetch_cycle_n === 1'b0)
        k++;
    end
    chk(16'(stopped_indicator_n), 16'h0);
    chk(16'(k != 0), 16'h1);
    int_enable <= 1'b1;
    mint_n <= 1'b0;
    expq.push_back({cbc_pkg::CBC_INTA, VEC});
    drain();
    chk(16'(stopped_indicator_n), 16'h1);
    mint_n <= 1'b1;
    int_enable <= 1'b0;
    chk(16'(expq.size()), 16'h0);
    summarize();
  end
  // The whole sequence needs well under a thousand cycles
  initial begin
    #400000;
    n_errors++;
    summarize();
  end
endmodule : tb_top
`default_nettype wire
